// [rtl/bo_detect_ctrl.sv]
// Purpose: brownout and power-on detect control with APB registers
// Assumes: comparator and power-on detector are async levels
// Notes: analog trip levels and power mode behaviour are outside
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "bo_detect_cfg.svh"
module brownout_poweron_detect_ctrl
	import bo_detect_pkg::*;
(
	input wire logic pclk, // system clock 100 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [11:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic bo_nv_config, // nonvolatile config, 1 = programmed
	input wire logic supply_below_trip, // comparator: supply below trip
	input wire logic poweron_detect, // initial power-up detected
	output logic bo_reset_req, // processor reset request
	output logic bo_irq_req, // brownout interrupt request
	output logic bo_detect_active // detection circuitry enabled
);
	logic [1:0] power_reduce_mode; // power reduction mode field
	logic bo_irq_select; // route brownout to interrupt
	logic bo_detect_powerdown; // brownout detect power-down
	logic bo_irq_enable; // brownout interrupt enable
	logic global_irq_enable; // global interrupt enable
	logic bo_flag; // sticky brownout flag
	logic poweron_flag; // sticky power-on flag
	logic cfg_sync; // synchronised config bit
	logic below_sync; // synchronised comparator
	logic por_sync; // synchronised power-on detect
	logic por_seen; // power-on level seen last cycle
	logic next_por_seen;
	logic [1:0] next_power_reduce_mode;
	logic next_bo_irq_select;
	logic next_bo_detect_powerdown;
	logic next_bo_irq_enable;
	logic next_global_irq_enable;
	logic next_bo_flag;
	logic next_poweron_flag;
	logic [31:0] next_prdata;
	logic next_pslverr;
	logic next_reset_req;
	logic next_irq_req;
	logic next_active;
	logic detect_en; // detection enabled now
	logic brownout; // brownout condition now
	logic por_rise; // power-on event pulse
	logic wr_access; // apb write access phase
	logic rd_access; // apb read setup phase, data registered for the access edge
	logic wr_setup; // apb write setup phase, error registered for the access edge
	logic addr_ok; // address is mapped
	power_mode_t mode; // decoded mode field

	// synchronisers for the three asynchronous inputs
	bo_sync2 cfg_sy (.pclk(pclk), .presetn(presetn), .d(bo_nv_config), .q(cfg_sync));
	bo_sync2 bel_sy (.pclk(pclk), .presetn(presetn), .d(supply_below_trip), .q(below_sync));
	bo_sync2 por_sy (.pclk(pclk), .presetn(presetn), .d(poweron_detect), .q(por_sync));

	assign mode = power_mode_t'(power_reduce_mode);
	assign wr_access = psel && penable && pwrite;
	assign rd_access = psel && !penable && !pwrite;
	assign wr_setup = psel && !penable && pwrite;
	assign por_rise = por_sync && !por_seen;

	// detection enable and brownout condition
	always_comb begin
		detect_en = cfg_sync && (mode != mode_total_pd) && !bo_detect_powerdown;
		brownout = detect_en && below_sync;
	end

	// apb address decode
	always_comb begin
		unique case (paddr)
			`ADDR_POWER_CONTROL, `ADDR_IRQ_ENABLE0, `ADDR_RESET_SOURCE, `ADDR_STATUS: begin
				addr_ok = 1'b1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// control register next values
	always_comb begin
		next_power_reduce_mode = power_reduce_mode;
		next_bo_irq_select = bo_irq_select;
		next_bo_detect_powerdown = bo_detect_powerdown;
		next_bo_irq_enable = bo_irq_enable;
		next_global_irq_enable = global_irq_enable;
		if (wr_access && paddr == `ADDR_POWER_CONTROL) begin
			next_power_reduce_mode = pwdata[`BIT_MODE_HI:`BIT_MODE_LO];
			next_bo_irq_select = pwdata[`BIT_IRQ_SELECT];
			next_bo_detect_powerdown = pwdata[`BIT_DETECT_PD];
		end
		if (wr_access && paddr == `ADDR_IRQ_ENABLE0) begin
			next_bo_irq_enable = pwdata[`BIT_BO_IRQ_EN];
			next_global_irq_enable = pwdata[`BIT_GLOBAL_EN];
		end
	end

	// sticky flag next values; hardware set wins over software clear
	always_comb begin
		next_bo_flag = bo_flag;
		next_poweron_flag = poweron_flag;
		next_por_seen = por_sync;
		if (wr_access && paddr == `ADDR_RESET_SOURCE && !pwdata[`BIT_BO_FLAG]) begin
			next_bo_flag = 1'b0;
		end
		if (wr_access && paddr == `ADDR_RESET_SOURCE && !pwdata[`BIT_POWERON_FLAG]) begin
			next_poweron_flag = 1'b0;
		end
		if (brownout) begin
			next_bo_flag = 1'b1;
		end
		if (por_rise) begin
			next_poweron_flag = 1'b1;
			// programmed config also sets brownout flag
			if (cfg_sync) begin
				next_bo_flag = 1'b1;
			end
		end
	end

	// response outputs and read data
	always_comb begin
		next_reset_req = brownout && !bo_irq_select;
		// irq path gated by all enables
		next_irq_req = detect_en && bo_irq_select && bo_irq_enable && global_irq_enable &&
			(bo_flag || brownout);
		next_active = detect_en;
		next_prdata = 32'h0000_0000;
		next_pslverr = 1'b0;
		if (rd_access) begin
			unique case (paddr)
				`ADDR_POWER_CONTROL: begin
					next_prdata[`BIT_MODE_HI:`BIT_MODE_LO] = power_reduce_mode;
					next_prdata[`BIT_IRQ_SELECT] = bo_irq_select;
					next_prdata[`BIT_DETECT_PD] = bo_detect_powerdown;
				end
				`ADDR_IRQ_ENABLE0: begin
					next_prdata[`BIT_BO_IRQ_EN] = bo_irq_enable;
					next_prdata[`BIT_GLOBAL_EN] = global_irq_enable;
				end
				`ADDR_RESET_SOURCE: begin
					next_prdata[`BIT_BO_FLAG] = bo_flag;
					next_prdata[`BIT_POWERON_FLAG] = poweron_flag;
				end
				`ADDR_STATUS: begin
					next_prdata[0] = detect_en;
					next_prdata[1] = below_sync;
					next_prdata[2] = cfg_sync;
				end
				default: begin
					next_pslverr = 1'b1;
				end
			endcase
		end
		// decode in setup so the answer stands at the completing edge
		if (wr_setup && !addr_ok) begin
			next_pslverr = 1'b1;
		end
	end

	// register all state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_reduce_mode <= 2'h0;
			bo_irq_select <= 1'b0;
			bo_detect_powerdown <= 1'b0;
			bo_irq_enable <= 1'b0;
			global_irq_enable <= 1'b0;
			bo_flag <= 1'b0;
			poweron_flag <= 1'b0;
			por_seen <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
			pready <= 1'b0;
			bo_reset_req <= 1'b0;
			bo_irq_req <= 1'b0;
			bo_detect_active <= 1'b0;
		end else begin
			power_reduce_mode <= next_power_reduce_mode;
			bo_irq_select <= next_bo_irq_select;
			bo_detect_powerdown <= next_bo_detect_powerdown;
			bo_irq_enable <= next_bo_irq_enable;
			global_irq_enable <= next_global_irq_enable;
			bo_flag <= next_bo_flag;
			poweron_flag <= next_poweron_flag;
			por_seen <= next_por_seen;
			prdata <= next_prdata;
			pslverr <= next_pslverr;
			pready <= 1'b1;
			bo_reset_req <= next_reset_req;
			bo_irq_req <= next_irq_req;
			bo_detect_active <= next_active;
		end
	end

	reset_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
		(brownout && !bo_irq_select) |=> bo_reset_req) else $error("no brownout reset");
	sel_blocks_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		bo_irq_select |=> !bo_reset_req) else $error("reset while irq selected");
	cfg_off_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cfg_sync |=> !bo_detect_active && !bo_reset_req) else $error("active unconfigured");
	mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		(power_reduce_mode == 2'h3) |=> !bo_detect_active) else $error("active in mode 11");
	pd_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		bo_detect_powerdown |=> !bo_irq_req && !bo_reset_req) else $error("response in pd");
	flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		brownout |=> bo_flag) else $error("brownout flag not set");
	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(bo_flag && !(wr_access && paddr == `ADDR_RESET_SOURCE)) |=> bo_flag)
		else $error("brownout flag lost");
	por_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		(poweron_flag && !(wr_access && paddr == `ADDR_RESET_SOURCE)) |=> poweron_flag)
		else $error("power-on flag lost");
	por_both_a: assert property (@(posedge pclk) disable iff (!presetn)
		(por_rise && cfg_sync) |=> bo_flag && poweron_flag) else $error("flags not both set");
	irq_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		bo_irq_req |-> $past(bo_irq_enable) && $past(global_irq_enable) && $past(bo_irq_select))
		else $error("irq without enables");
endmodule

// [rtl/bo_detect_cfg.svh]
// Purpose: constants for the brownout and power-on detect controller
// Assumes: 32-bit APB, one word per register, byte addresses below
// Notes: bit positions follow the power, irq enable and reset source layouts
`ifndef BO_DETECT_CFG_SVH
`define BO_DETECT_CFG_SVH
`define ADDR_POWER_CONTROL 12'h000
`define ADDR_IRQ_ENABLE0 12'h004
`define ADDR_RESET_SOURCE 12'h008
`define ADDR_STATUS 12'h00C
`define BIT_MODE_LO 0
`define BIT_MODE_HI 1
`define BIT_IRQ_SELECT 4
`define BIT_DETECT_PD 5
`define BIT_BO_IRQ_EN 5
`define BIT_GLOBAL_EN 7
`define BIT_POWERON_FLAG 4
`define BIT_BO_FLAG 5
`define MODE_TOTAL_PD 2'h3
`define POWER_CONTROL_RST 8'h00
`define IRQ_ENABLE0_RST 8'h00
`endif

// [rtl/bo_detect_pkg.sv]
// Purpose: types for the brownout and power-on detect controller
// Assumes: nothing
// Notes: mode encoding of the power reduction field
package bo_detect_pkg;
	typedef enum logic [1:0] {
		mode_normal = 2'h0,
		mode_idle = 2'h1,
		mode_powerdown = 2'h2,
		mode_total_pd = 2'h3
	} power_mode_t;
endpackage

// [rtl/bo_sync2.sv]
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: one clock, active-low asynchronous reset
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module bo_sync2 (
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic d, // asynchronous level
	output logic q // synchronised level
);
	logic stage1; // first stage, metastable hazard
	logic next_stage1; // next first stage
	logic next_q; // next second stage

	// next values: plain shift
	always_comb begin
		next_stage1 = d;
		next_q = stage1;
	end

	// register both stages
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1 <= 1'b0;
			q <= 1'b0;
		end else begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule

// [tb/bo_supply_model.sv]
// Purpose: stand-in for the supply comparator and power-on detector
// Assumes: both levels are asynchronous to pclk
// Notes: levels move a few ns after the bench command, off the clock edge
`timescale 1ns/1ps
module bo_supply_model (
	input wire logic below_cmd, // bench asks for a supply dip
	input wire logic por_cmd, // bench asks for a power-up event
	output logic supply_below_trip, // comparator level
	output logic poweron_detect // power-on detector level
);
	assign #3 supply_below_trip = below_cmd;
	assign #4 poweron_detect = por_cmd;
endmodule

// [tb/brownout_poweron_detect_ctrl_tb.sv]
// Purpose: self-checking bench for the brownout and power-on controller
// Assumes: zero-wait apb, outputs settle 3 cycles after an input pin moves
// Notes: table rows cover enable decoding, hand tests cover the flags
`timescale 1ns/1ps
`include "bo_detect_cfg.svh"
module brownout_poweron_detect_ctrl_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0; // bus and clock
	logic [11:0] paddr = 12'h000; // bus address
	logic [31:0] pwdata = 32'h0, prdata, rd; // bus data, last read
	logic pready, pslverr, err, nv = 0, below_cmd = 0, por_cmd = 0; // status and commands
	logic below, por, rst_req, irq, act; // model levels and outputs
	logic [9:0] r; // current row
	// row: nv, mode[1:0], pd, sel, en, ga, then active, reset, irq
	logic [9:0] rows [7] = '{10'b1000000110, 10'b0000000000, 10'b1110000000,
		10'b1011000000, 10'b1100111101, 10'b1010101100, 10'b1000110100};
	int mismatches = 0, n_compared = 0;
	always #5 pclk = ~pclk;
	brownout_poweron_detect_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .bo_nv_config(nv),
		.supply_below_trip(below), .poweron_detect(por), .bo_reset_req(rst_req),
		.bo_irq_req(irq), .bo_detect_active(act));
	bo_supply_model model (.below_cmd(below_cmd), .por_cmd(por_cmd),
		.supply_below_trip(below), .poweron_detect(por));
	task automatic give_verdict();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: bit %b, expected %b", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: word %h, expected %h", $time, got, exp);
		end
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer; error and read data taken at the completing edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			mismatches++;
			give_verdict();
		end
		err = pslverr;
		rd = prdata;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	initial begin
		settle(16);
		presetn <= 1;
		settle(1);
		// enable decoding and response routing, one row each
		foreach (rows[i]) begin
			r = rows[i];
			nv <= r[9];
			apb(1, `ADDR_POWER_CONTROL, {26'h0, r[6], r[5], 2'h0, r[8:7]});
			apb(1, `ADDR_IRQ_ENABLE0, {24'h0, r[3], 1'b0, r[4], 5'h0});
			below_cmd <= 1;
			settle(6);
			chk_bit(act, r[2]);
			chk_bit(rst_req, r[1]);
			chk_bit(irq, r[0]);
			below_cmd <= 0;
			settle(6);
			chk_bit(rst_req, 1'b0);
			apb(0, `ADDR_RESET_SOURCE, 32'h0);
			chk_word(rd, {26'h0, r[2], 5'h0});
			apb(1, `ADDR_RESET_SOURCE, 32'h0);
			$display("row %0d done", i);
		end
		// interrupt held by the sticky flag, ones written leave it alone
		nv <= 1;
		apb(1, `ADDR_POWER_CONTROL, 32'h10);
		apb(1, `ADDR_IRQ_ENABLE0, 32'hA0);
		below_cmd <= 1;
		settle(6);
		below_cmd <= 0;
		settle(6);
		chk_bit(irq, 1'b1);
		apb(1, `ADDR_RESET_SOURCE, 32'hFFFFFFFF);
		apb(0, `ADDR_RESET_SOURCE, 32'h0);
		chk_word(rd, 32'h20);
		apb(1, `ADDR_RESET_SOURCE, 32'h0);
		settle(3);
		chk_bit(irq, 1'b0);
		$display("sticky irq test done");
		// power-up event sets both flags, power-on flag kept while the brownout flag is cleared
		por_cmd <= 1;
		settle(6);
		apb(0, `ADDR_RESET_SOURCE, 32'h0);
		chk_word(rd, 32'h30);
		apb(1, `ADDR_RESET_SOURCE, 32'h10);
		apb(0, `ADDR_RESET_SOURCE, 32'h0);
		chk_word(rd, 32'h10);
		por_cmd <= 0;
		nv <= 0;
		apb(1, `ADDR_RESET_SOURCE, 32'h0);
		por_cmd <= 1;
		settle(6);
		apb(0, `ADDR_RESET_SOURCE, 32'h0);
		// brownout bit masked out: meaningless while unprogrammed
		chk_word(rd & 32'h10, 32'h10);
		por_cmd <= 0;
		$display("power-on test done");
		// unmapped address is refused and reads zero
		apb(0, 12'h010, 32'h0);
		chk_bit(err, 1'b1);
		chk_word(rd, 32'h0);
		$display("unmapped test done");
		// reset in mid-run clears controls, detection comes back on
		nv <= 1;
		presetn <= 0;
		settle(2);
		presetn <= 1;
		settle(6);
		chk_bit(act, 1'b1);
		apb(0, `ADDR_POWER_CONTROL, 32'h0);
		chk_word(rd, 32'h0);
		apb(0, `ADDR_IRQ_ENABLE0, 32'h0);
		chk_word(rd, 32'h0);
		$display("reset test done");
		give_verdict();
	end
endmodule
